// file: design/gdc_ctrl.sv
// gate driver controller: bus registers, drive pin, event handling
`timescale 1ns/1ps
`default_nettype none
module gdc_ctrl #(
    parameter int ACK_WAIT = gdc_pkg::ACK_WAIT_CYC,   // default ack window in cycles
    parameter int FAULT_MIN = gdc_pkg::FAULT_MIN_CYC  // default fault low length
) (
    input wire logic I_REF_CLK,
    input wire logic I_RST,
    input wire logic i_CE,
    input wire logic i_HSEL,
    input wire logic [31:0] i_HADDR,
    input wire logic [1:0] i_HTRANS,
    input wire logic i_HWRITE,
    input wire logic [2:0] i_HSIZE,
    input wire logic [31:0] i_HWDATA,
    input wire logic i_HREADY,
    input wire logic i_STATUS_LINK,
    output logic [31:0] o_HRDATA,
    output logic o_HREADYOUT,
    output logic o_HRESP,
    output logic o_DRIVE_LINK,
    output logic o_IRQ
);
    gdc_mon_if mi ();

    logic [gdc_pkg::CTRL_W-1:0] ctrl_q, ctrl_d;     // software control bits
    logic [gdc_pkg::CNT_W-1:0] win_q, win_d;        // ack window
    logic [gdc_pkg::CNT_W-1:0] flen_q, flen_d;      // fault length
    logic [gdc_pkg::EV_W-1:0] stat_q, stat_d;       // sticky events
    logic [gdc_pkg::EV_W-1:0] mask_q, mask_d;       // interrupt mask
    logic forced_q, forced_d;                        // drive held off
    logic drive_q, drive_d;                          // drive pin level
    logic edge_q, edge_d;                            // drive pin toggled
    logic irq_q, irq_d;
    logic [31:0] rdata_q, rdata_d;
    logic wr_q, wr_d;                                // write data phase pending
    logic [7:0] wadr_q, wadr_d;                      // latched write offset
    logic addr_ok, cmd_on;
    logic [gdc_pkg::EV_W-1:0] ev_set, rd_clr;

    // status monitor, one per driver channel
    gdc_status_mon u_mon (
        .i_clk(I_REF_CLK),
        .i_rst(I_RST),
        .i_ce(i_CE),
        .i_status(i_STATUS_LINK),
        .m(mi.mon)
    );

    assign mi.cmd_edge = edge_q;
    assign mi.ack_en = ctrl_q[gdc_pkg::CTRL_ACKEN];
    assign mi.ack_win = win_q;
    assign mi.fault_len = flen_q;

    // next values of every register
    always_comb begin
        ctrl_d = ctrl_q;
        win_d = win_q;
        flen_d = flen_q;
        mask_d = mask_q;
        forced_d = forced_q;
        rdata_d = 32'h0000_0000;
        rd_clr = '0;
        ev_set = '0;
        ev_set[gdc_pkg::EV_FAULT] = mi.ev_fault;
        ev_set[gdc_pkg::EV_MISSING] = mi.ev_missing;
        ev_set[gdc_pkg::EV_SPURIOUS] = mi.ev_spurious;
        // address phase taken when selected and active
        addr_ok = i_HSEL && i_HREADY && i_HTRANS[gdc_pkg::HTRANS_ACT];
        wr_d = addr_ok && i_HWRITE;
        wadr_d = addr_ok ? i_HADDR[7:0] : wadr_q;
        // reads are answered from a register in the data phase
        if (addr_ok && !i_HWRITE) begin
            case (i_HADDR[7:0])
                gdc_pkg::OFS_CTRL: rdata_d[gdc_pkg::CTRL_W-1:0] = ctrl_q;
                gdc_pkg::OFS_ACK_WIN: rdata_d[gdc_pkg::CNT_W-1:0] = win_q;
                gdc_pkg::OFS_FAULT_LEN: rdata_d[gdc_pkg::CNT_W-1:0] = flen_q;
                gdc_pkg::OFS_STATUS: begin
                    rdata_d[gdc_pkg::EV_W-1:0] = stat_q;
                    rd_clr = stat_q; // read clears what it returned
                end
                gdc_pkg::OFS_MASK: rdata_d[gdc_pkg::EV_W-1:0] = mask_q;
                gdc_pkg::OFS_STATE: begin
                    rdata_d[gdc_pkg::ST_LINK] = mi.link_ok;
                    rdata_d[gdc_pkg::ST_DRIVE] = drive_q;
                    rdata_d[gdc_pkg::ST_FORCED] = forced_q;
                end
                default: rdata_d = 32'h0000_0000; // unmapped reads zero
            endcase
        end
        // write data lands in the data phase
        if (wr_q) begin
            case (wadr_q)
                gdc_pkg::OFS_CTRL: begin
                    ctrl_d = i_HWDATA[gdc_pkg::CTRL_W-1:0];
                    // writing off acknowledges a forced shutdown
                    if (!i_HWDATA[gdc_pkg::CTRL_ON]) begin
                        forced_d = 1'b0;
                    end
                end
                gdc_pkg::OFS_ACK_WIN: win_d = i_HWDATA[gdc_pkg::CNT_W-1:0];
                gdc_pkg::OFS_FAULT_LEN: flen_d = i_HWDATA[gdc_pkg::CNT_W-1:0];
                gdc_pkg::OFS_MASK: mask_d = i_HWDATA[gdc_pkg::EV_W-1:0];
                default: ; // others ignore writes
            endcase
        end
        // series strings: fault makes the controller switch off, set wins
        if (mi.ev_fault && ctrl_q[gdc_pkg::CTRL_SERIES]) begin
            forced_d = 1'b1;
        end
        // new event beats a read clear in the same cycle
        stat_d = (stat_q & ~rd_clr) | ev_set;
        irq_d = |(stat_d & mask_d);
        cmd_on = ctrl_d[gdc_pkg::CTRL_ON] && !forced_d;
        // pin encoding: low means on unless the polarity bit is set
        drive_d = ctrl_d[gdc_pkg::CTRL_POL] ? cmd_on : !cmd_on;
        edge_d = drive_d != drive_q;
    end

    // register stage, frozen while clock enable is low
    always_ff @(posedge I_REF_CLK or posedge I_RST) begin
        if (I_RST) begin
            ctrl_q <= gdc_pkg::CTRL_RST;
            win_q <= gdc_pkg::CNT_W'(ACK_WAIT);
            flen_q <= gdc_pkg::CNT_W'(FAULT_MIN);
            stat_q <= '0;
            mask_q <= gdc_pkg::MASK_RST;
            forced_q <= 1'b0;
            drive_q <= 1'b1;
            edge_q <= 1'b0;
            irq_q <= 1'b0;
            rdata_q <= 32'h0000_0000;
            wr_q <= 1'b0;
            wadr_q <= 8'h00;
        end else if (i_CE) begin
            ctrl_q <= ctrl_d;
            win_q <= win_d;
            flen_q <= flen_d;
            stat_q <= stat_d;
            mask_q <= mask_d;
            forced_q <= forced_d;
            drive_q <= drive_d;
            edge_q <= edge_d;
            irq_q <= irq_d;
            rdata_q <= rdata_d;
            wr_q <= wr_d;
            wadr_q <= wadr_d;
        end
    end

    // zero wait state, always OKAY
    assign o_HRDATA = rdata_q;
    assign o_HREADYOUT = 1'b1;
    assign o_HRESP = 1'b0;
    assign o_DRIVE_LINK = drive_q;
    assign o_IRQ = irq_q;

    // pin level matches the commanded state and polarity
    property p_pol;
        @(posedge I_REF_CLK) disable iff (I_RST)
        drive_q == (ctrl_q[gdc_pkg::CTRL_POL] ? (ctrl_q[gdc_pkg::CTRL_ON] && !forced_q)
                                              : !(ctrl_q[gdc_pkg::CTRL_ON] && !forced_q));
    endproperty
    a_pol: assert property (p_pol) else $error("drive pin polarity wrong");
    // series fault forces the drive off within one cycle; off level is the inverse of polarity
    property p_series_off;
        @(posedge I_REF_CLK) disable iff (I_RST)
        (i_CE && mi.ev_fault && ctrl_q[gdc_pkg::CTRL_SERIES]) |=> forced_q && (drive_q == !ctrl_q[gdc_pkg::CTRL_POL]);
    endproperty
    a_series_off: assert property (p_series_off) else $error("series fault did not force off");
    // event sets status even while a read clears it
    property p_sticky;
        @(posedge I_REF_CLK) disable iff (I_RST)
        (i_CE && mi.ev_missing) |=> stat_q[gdc_pkg::EV_MISSING];
    endproperty
    a_sticky: assert property (p_sticky) else $error("missing-ack event lost");
    // noisy receiver event reaches status
    property p_spur_stat;
        @(posedge I_REF_CLK) disable iff (I_RST)
        (i_CE && mi.ev_spurious) |=> stat_q[gdc_pkg::EV_SPURIOUS];
    endproperty
    a_spur_stat: assert property (p_spur_stat) else $error("spurious event lost");
    // interrupt changes with unmasked status in the same cycle
    property p_irq;
        @(posedge I_REF_CLK) disable iff (I_RST)
        i_CE |=> o_IRQ == |($past(stat_d) & $past(mask_d));
    endproperty
    a_irq: assert property (p_irq) else $error("interrupt level wrong");
    // each drive toggle announces an edge to the monitor
    property p_edge;
        @(posedge I_REF_CLK) disable iff (I_RST)
        (i_CE && drive_d != drive_q) |=> edge_q ##0 $changed(drive_q);
    endproperty
    a_edge: assert property (p_edge) else $error("drive edge not announced");
    c_forced: cover property (@(posedge I_REF_CLK) disable iff (I_RST) $rose(forced_q));
    c_irq: cover property (@(posedge I_REF_CLK) disable iff (I_RST) $rose(o_IRQ));
endmodule : gdc_ctrl
`default_nettype wire

// file: design/gdc_mon_if.sv
// link between register/drive logic and the status monitor
`timescale 1ns/1ps
`default_nettype none
interface gdc_mon_if;
    logic cmd_edge;                     // drive pin toggled, one cycle
    logic ack_en;                       // ack checking on
    logic [gdc_pkg::CNT_W-1:0] ack_win; // cycles to wait for an ack
    logic [gdc_pkg::CNT_W-1:0] fault_len; // low cycles that mean fault
    logic ev_fault;                     // fault pulse
    logic ev_missing;                   // missing ack pulse
    logic ev_spurious;                  // unexpected ack pulse
    logic link_ok;                      // filtered status level
    modport ctrl (output cmd_edge, ack_en, ack_win, fault_len, input ev_fault, ev_missing, ev_spurious, link_ok);
    modport mon (input cmd_edge, ack_en, ack_win, fault_len, output ev_fault, ev_missing, ev_spurious, link_ok);
endinterface : gdc_mon_if
`default_nettype wire

// file: design/gdc_pkg.sv
// shared constants for the gate driver controller
package gdc_pkg;
    // register byte offsets on the bus
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_ACK_WIN = 8'h04;
    localparam logic [7:0] OFS_FAULT_LEN = 8'h08;
    localparam logic [7:0] OFS_STATUS = 8'h0C;
    localparam logic [7:0] OFS_MASK = 8'h10;
    localparam logic [7:0] OFS_STATE = 8'h14;
    // control fields
    localparam int CTRL_ON = 0;
    localparam int CTRL_POL = 1;
    localparam int CTRL_SERIES = 2;
    localparam int CTRL_ACKEN = 3;
    localparam int CTRL_W = 4;
    // sticky event fields, same layout in mask
    localparam int EV_FAULT = 0;
    localparam int EV_MISSING = 1;
    localparam int EV_SPURIOUS = 2;
    localparam int EV_W = 3;
    // live state fields
    localparam int ST_LINK = 0;
    localparam int ST_DRIVE = 1;
    localparam int ST_FORCED = 2;
    // timing: clock period and documented times
    localparam int CLK_PERIOD_PS = 5000;
    localparam int ACK_WAIT_NS = 2000;
    localparam int FAULT_MIN_NS = 2000;
    // least times round up to whole cycles
    localparam int ACK_WAIT_CYC = (ACK_WAIT_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int FAULT_MIN_CYC = (FAULT_MIN_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int CNT_W = 16;
    // reset values
    localparam logic [CTRL_W-1:0] CTRL_RST = 4'h8;
    localparam logic [EV_W-1:0] MASK_RST = 3'h0;
    // transfer type bit that marks an active transfer
    localparam int HTRANS_ACT = 1;
endpackage : gdc_pkg

// file: design/gdc_status_mon.sv
// status fibre monitor: filter, ack window, pulse classification
`timescale 1ns/1ps
`default_nettype none
module gdc_status_mon (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_ce,
    input wire logic i_status,
    gdc_mon_if.mon m
);
    logic [2:0] sync_q, sync_d;          // three stage synchroniser
    logic lvl_q, lvl_d;                  // accepted level
    logic [gdc_pkg::CNT_W-1:0] win_q, win_d;  // ack window countdown
    logic [gdc_pkg::CNT_W-1:0] low_q, low_d;  // length of current low
    logic exp_q, exp_d;                  // current low was expected
    logic flt_q, flt_d;                  // fault already flagged this low
    logic ev_f_q, ev_f_d, ev_m_q, ev_m_d, ev_s_q, ev_s_d;
    logic fall, rise;

    // next-state computation
    always_comb begin
        sync_d = {sync_q[1:0], i_status};
        // change accepted only once stages two and three agree
        lvl_d = (sync_q[2] == sync_q[1]) ? sync_q[2] : lvl_q;
        fall = lvl_q & ~lvl_d;
        rise = ~lvl_q & lvl_d;
        win_d = win_q;
        low_d = low_q;
        exp_d = exp_q;
        flt_d = flt_q;
        ev_f_d = 1'b0;
        ev_m_d = 1'b0;
        ev_s_d = 1'b0;
        // each commanded edge opens a fresh window
        if (m.cmd_edge) begin
            win_d = m.ack_win;
        end else if (win_q != '0) begin
            win_d = win_q - 1'b1;
            // an ack landing in the last window cycle still counts as answered
            if (win_q == 1 && m.ack_en && !fall) begin
                ev_m_d = 1'b1;
            end
        end
        if (fall) begin
            // an ack during an open window closes it
            exp_d = (win_q != '0) | m.cmd_edge;
            win_d = '0;
            low_d = '0;
            flt_d = 1'b0;
        end else if (!lvl_q) begin
            // saturate so very long lows stay a fault
            if (low_q != '1) begin
                low_d = low_q + 1'b1;
            end
            if (low_q == m.fault_len && !flt_q) begin
                ev_f_d = 1'b1;
                flt_d = 1'b1;
            end
        end
        // short low with no edge before it: noisy receiver
        if (rise && !flt_q && !exp_q && m.ack_en) begin
            ev_s_d = 1'b1;
        end
    end

    // state registers, frozen while clock enable is low
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            sync_q <= 3'h0;
            lvl_q <= 1'b0;
            win_q <= '0;
            low_q <= '0;
            exp_q <= 1'b0;
            flt_q <= 1'b1;
            ev_f_q <= 1'b0;
            ev_m_q <= 1'b0;
            ev_s_q <= 1'b0;
        end else if (i_ce) begin
            sync_q <= sync_d;
            lvl_q <= lvl_d;
            win_q <= win_d;
            low_q <= low_d;
            exp_q <= exp_d;
            flt_q <= flt_d;
            ev_f_q <= ev_f_d;
            ev_m_q <= ev_m_d;
            ev_s_q <= ev_s_d;
        end
    end

    assign m.ev_fault = ev_f_q;
    assign m.ev_missing = ev_m_q;
    assign m.ev_spurious = ev_s_q;
    assign m.link_ok = lvl_q;

    // a window that runs out unanswered reports a missing ack
    property p_missing;
        @(posedge i_clk) disable iff (i_rst)
        (i_ce && win_q == 1 && !m.cmd_edge && !fall && m.ack_en) |=> ev_m_q;
    endproperty
    a_missing: assert property (p_missing) else $error("missing ack not flagged");
    // a spurious flag only follows a rising status level
    property p_spur;
        @(posedge i_clk) disable iff (i_rst)
        $rose(ev_s_q) |-> lvl_q && !$past(lvl_q, 2);
    endproperty
    a_spur: assert property (p_spur) else $error("spurious ack without pulse end");
    c_missing: cover property (@(posedge i_clk) disable iff (i_rst) ev_m_q);
    c_fault: cover property (@(posedge i_clk) disable iff (i_rst) ev_f_q);
endmodule : gdc_status_mon
`default_nettype wire

// file: testbench/gate_driver_fault_status_logic_test.sv
// self-checking bench: controller against the driver model
`timescale 1ns/1ps
`default_nettype none
module gate_driver_fault_status_logic_test;
    logic clk = 1'b0; // 200 MHz reference
    logic rst = 1'b1;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic pol = 1'b0;   // polarity strap, mirrors the control bit
    logic ser = 1'b0;   // series strap
    logic trip = 1'b0;  // desaturation trip
    logic uv = 1'b0;    // undervoltage
    logic noise = 1'b0; // noisy receiver
    logic cap = 1'b1;   // ack capacitor fitted
    logic ce = 1'b1;    // clock enable, dropped once to prove the freeze
    wire logic [31:0] hrdata;
    wire logic hready, hresp, drv, irq, stat, gate;
    logic [31:0] rd;
    logic [31:0] rng = 32'h63; // xorshift state
    int n_fail = 0;
    int num_checks = 0;
    // short windows keep the run brief
    gdc_ctrl #(.ACK_WAIT(8), .FAULT_MIN(20)) dut_u (.I_REF_CLK(clk), .I_RST(rst), .i_CE(ce),
        .i_HSEL(hsel), .i_HADDR(haddr), .i_HTRANS(htrans), .i_HWRITE(hwrite), .i_HSIZE(3'h2),
        .i_HWDATA(hwdata), .i_HREADY(hready), .i_STATUS_LINK(stat), .o_HRDATA(hrdata),
        .o_HREADYOUT(hready), .o_HRESP(hresp), .o_DRIVE_LINK(drv), .o_IRQ(irq));
    // model keeps its default ack length (4) and blocking time (40)
    gdc_drv_model drv_u (.i_clk(clk), .i_rst(rst), .i_drive_link(drv),
        .i_polarity_select(pol), .i_series_mode_select(ser), .i_desat_sense(trip), .i_undervolt(uv),
        .i_noise(noise), .i_ack_pulse_cap(cap), .o_status_link(stat), .o_gate_on(gate));
    // clock
    initial begin
        forever #2.5 clk = ~clk;
    end
    function automatic logic [31:0] xs(input logic [31:0] s);
        s ^= s << 13;
        s ^= s >> 17;
        s ^= s << 5;
        return s;
    endfunction : xs
    // expected pin level for an on request under a polarity
    function automatic logic exp_pin(input logic on, input logic p);
        return p ? on : ~on;
    endfunction : exp_pin
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask : cyc
    // one single transfer; entered just after a rising edge
    task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] wd);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        htrans <= 2'h2;
        hwrite <= w;
        do @(posedge clk); while (hready !== 1'b1);
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge clk); while (hready !== 1'b1);
        rd = hrdata;
    endtask : xfer
    task automatic chk_word(input string nm, input logic [31:0] e, input logic [31:0] g);
        num_checks++;
        if (g !== e) begin
            n_fail++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask : chk_word
    task automatic chk_bit(input string nm, input logic e, input logic g);
        chk_word(nm, {31'h0, e}, {31'h0, g});
    endtask : chk_bit
    task automatic rdchk(input logic [7:0] a, input logic [31:0] e, input string nm);
        xfer(a, 1'b0, 32'h0);
        chk_word(nm, e, rd);
        chk_bit("okay response", 1'b0, hresp);
    endtask : rdchk
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : wrap_up
    // watchdog well past the expected run length
    initial begin
        #100000;
        n_fail++;
        wrap_up();
    end
    // main sequence
    initial begin
        cyc(12);
        chk_bit("drive in reset", 1'b1, drv);
        chk_bit("irq in reset", 1'b0, irq);
        rst <= 1'b0;
        @(posedge clk);
        rdchk(gdc_pkg::OFS_CTRL, 32'h8, "ctrl reset");
        rdchk(gdc_pkg::OFS_ACK_WIN, 32'h8, "ack window reset");
        rdchk(gdc_pkg::OFS_FAULT_LEN, 32'h14, "fault length reset");
        rdchk(gdc_pkg::OFS_MASK, 32'h0, "mask reset");
        rdchk(gdc_pkg::OFS_STATE, 32'h3, "idle state");
        rdchk(8'h18, 32'h0, "unmapped");
        xfer(gdc_pkg::OFS_MASK, 1'b1, 32'h7);
        // random on/polarity commands, every edge acknowledged
        for (int i = 0; i < 10; i++) begin
            rng = xs(rng);
            pol <= rng[1];
            xfer(gdc_pkg::OFS_CTRL, 1'b1, {28'h0, 2'b10, rng[1], rng[0]});
            cyc(16);
            chk_bit("drive pin", exp_pin(rng[0], rng[1]), drv);
            chk_bit("gate", rng[0], gate);
            rdchk(gdc_pkg::OFS_STATUS, 32'h0, "status quiet");
        end
        pol <= 1'b0;
        xfer(gdc_pkg::OFS_CTRL, 1'b1, 32'h9);
        cyc(16);
        rdchk(gdc_pkg::OFS_STATUS, 32'h0, "status quiet");
        // no capacitor: acks vanish; with checking off nothing is flagged
        cap <= 1'b0;
        xfer(gdc_pkg::OFS_CTRL, 1'b1, 32'h0);
        cyc(16);
        rdchk(gdc_pkg::OFS_STATUS, 32'h0, "ack check off");
        // checking on: missing ack raises the interrupt, stalled while enable is low
        xfer(gdc_pkg::OFS_CTRL, 1'b1, 32'h9);
        ce <= 1'b0;
        cyc(20);
        chk_bit("irq frozen", 1'b0, irq);
        ce <= 1'b1;
        cyc(16);
        chk_bit("irq missing ack", 1'b1, irq);
        rdchk(gdc_pkg::OFS_STATUS, 32'h2, "missing ack");
        cyc(3);
        chk_bit("irq cleared", 1'b0, irq);
        cap <= 1'b1;
        // ack-like pulse with no commanded edge
        noise <= 1'b1;
        cyc(4);
        noise <= 1'b0;
        cyc(12);
        rdchk(gdc_pkg::OFS_STATUS, 32'h4, "spurious ack");
        // normal mode fault: gate blocked, then released
        xfer(gdc_pkg::OFS_CTRL, 1'b1, 32'h9);
        cyc(16);
        trip <= 1'b1;
        @(posedge clk);
        trip <= 1'b0;
        cyc(3);
        chk_bit("gate blocked", 1'b0, gate);
        chk_bit("pin still on", 1'b0, drv);
        cyc(30);
        chk_bit("status blocking", 1'b0, stat);
        rdchk(gdc_pkg::OFS_STATUS, 32'h1, "fault");
        cyc(15);
        chk_bit("gate released", 1'b1, gate);
        chk_bit("status healthy", 1'b1, stat);
        // series mode: gate kept, controller turns it off
        ser <= 1'b1;
        xfer(gdc_pkg::OFS_CTRL, 1'b1, 32'hD);
        cyc(4);
        trip <= 1'b1;
        @(posedge clk);
        trip <= 1'b0;
        cyc(3);
        chk_bit("series gate kept", 1'b1, gate);
        cyc(30);
        chk_bit("series pin off", 1'b1, drv);
        chk_bit("series gate off", 1'b0, gate);
        xfer(gdc_pkg::OFS_STATUS, 1'b0, 32'h0);
        chk_word("series fault", 32'h1, rd & 32'h1);
        cyc(20);
        xfer(gdc_pkg::OFS_CTRL, 1'b1, 32'h8);
        ser <= 1'b0;
        cyc(16);
        xfer(gdc_pkg::OFS_STATUS, 1'b0, 32'h0);
        rdchk(gdc_pkg::OFS_STATE, 32'h3, "forced off cleared");
        // undervoltage holds the status switch conducting
        uv <= 1'b1;
        cyc(2);
        chk_bit("status undervolt", 1'b0, stat);
        cyc(28);
        uv <= 1'b0;
        cyc(10);
        rdchk(gdc_pkg::OFS_STATUS, 32'h1, "undervolt fault");
        wrap_up();
    end
endmodule : gate_driver_fault_status_logic_test
`default_nettype wire

// file: testbench/gdc_drv_model.sv
// behavioural model of the gate driver as seen from both fibres
`timescale 1ns/1ps
`default_nettype none
module gdc_drv_model #(
    parameter int ACK_LEN = 4,   // ack pulse cycles with capacitor fitted
    parameter int BLOCK_LEN = 40 // blocking time cycles
) (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_drive_link,          // drive fibre level
    input wire logic i_polarity_select,     // strap: low inverts input
    input wire logic i_series_mode_select,  // strap: high reports only
    input wire logic i_desat_sense,         // one-cycle desaturation trip
    input wire logic i_undervolt,           // supply below threshold
    input wire logic i_noise,               // noisy receiver pulls status
    input wire logic i_ack_pulse_cap,       // ack capacitor fitted
    output logic o_status_link,             // high = light, healthy
    output logic o_gate_on                  // transistor conducts
);
    logic drive_q; // last drive level, for edge detect
    int ack_q;     // ack pulse cycles left
    int blk_q;     // blocking cycles left
    logic cmd_on;  // decoded on command
    // decode the drive level through the polarity strap
    assign cmd_on = i_polarity_select ? i_drive_link : ~i_drive_link;
    // counters; no capacitor gives a sub-cycle pulse, so nothing is seen
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            drive_q <= 1'b1;
            ack_q <= 0;
            blk_q <= 0;
        end else begin
            drive_q <= i_drive_link;
            if (i_desat_sense) begin
                blk_q <= BLOCK_LEN;
            end else if (blk_q != 0) begin
                blk_q <= blk_q - 1;
            end
            if (drive_q != i_drive_link) begin
                ack_q <= i_ack_pulse_cap ? ACK_LEN : 0;
            end else if (ack_q != 0) begin
                ack_q <= ack_q - 1;
            end
        end
    end
    // status switch conducts for any cause, until all have ended
    assign o_status_link = ~(i_undervolt | i_noise | (blk_q != 0) | (ack_q != 0));
    // normal mode blocks the gate on fault; series mode leaves it
    assign o_gate_on = cmd_on & (i_series_mode_select | (blk_q == 0 && !i_undervolt));
endmodule : gdc_drv_model
`default_nettype wire
